/* hbm_pkg.sv */
// shared constants and types for the eight-bit muxed host bus port
package hbm_pkg;

    // ----------------------------------------------------------------
    // mode selection values
    // ----------------------------------------------------------------
    localparam logic [3:0] HBM_TOP_MODE_HB8 = 4'h2;
    localparam logic [1:0] HBM_HB_MODE_MUX = 2'h0;

    // select arrangement encodings
    localparam logic [1:0] HBM_ARR_ALE = 2'h0;
    localparam logic [1:0] HBM_ARR_CS1 = 2'h1;
    localparam logic [1:0] HBM_ARR_CS2 = 2'h2;
    localparam logic [1:0] HBM_ARR_ALE_CS2 = 2'h3;

    // ----------------------------------------------------------------
    // pin positions on the interface signal vector
    // ----------------------------------------------------------------
    localparam int HBM_SIG_W = 32;
    localparam int HBM_AD_LO = 0;
    localparam int HBM_AD_HI = 7;
    localparam int HBM_UA_LO = 8;
    localparam int HBM_UA_HI = 18;
    localparam int HBM_PIN_CS0B = 26;
    localparam int HBM_PIN_CS1 = 27;
    localparam int HBM_PIN_RD = 28;
    localparam int HBM_PIN_WR = 29;
    localparam int HBM_PIN_ALECS = 30;
    localparam int HBM_ADDR_W = 19;

    // ----------------------------------------------------------------
    // timing, times in ns and derived cycle counts
    // ----------------------------------------------------------------
    localparam int HBM_CLK_NS = 25;
    localparam int HBM_ADDR_NS = 50;
    localparam int HBM_STROBE_NS = 50;
    // least times round up to whole cycles
    localparam int HBM_ADDR_CYC =
        (HBM_ADDR_NS + HBM_CLK_NS - 1) / HBM_CLK_NS;
    localparam int HBM_STROBE_CYC =
        (HBM_STROBE_NS + HBM_CLK_NS - 1) / HBM_CLK_NS;
    localparam logic [1:0] HBM_ADDR_LAST = 2'(HBM_ADDR_CYC - 1);
    localparam logic [1:0] HBM_STROBE_LAST = 2'(HBM_STROBE_CYC - 1);

    // access sequencer states
    typedef enum logic [2:0] {
        HBM_IDLE,
        HBM_ADDR,
        HBM_HOLD,
        HBM_STRB,
        HBM_GAP
    } hbm_state_t;

endpackage

/* hbm_ctl_if.sv */
// control bundle from the access sequencer to the pin mapper
`timescale 1ns/1ps
`default_nettype none
interface hbm_ctl_if;
    logic en;
    logic ale;
    logic cs_on;
    logic cs_idx;
    logic rd;
    logic wr;
    logic ad_oe;
    logic [7:0] ad_val;
    logic [18:0] addr;
    logic [1:0] arr;

    modport core (output en, ale, cs_on, cs_idx, rd, wr, ad_oe, ad_val,
                  output addr, arr);
    modport pins (input en, ale, cs_on, cs_idx, rd, wr, ad_oe, ad_val,
                  input addr, arr);
endinterface
`default_nettype wire

/* hbm_pin_map.sv */
// maps sequencer control onto the interface signal pins per arrangement
`timescale 1ns/1ps
`default_nettype none
module hbm_pin_map
    import hbm_pkg::*;
(
    hbm_ctl_if.pins ctl,
    output logic [31:0] sig_o,
    output logic [31:0] sig_oe
);

    // active-low select for one peripheral slot
    function automatic logic sel_n(input logic on, input logic idx,
                                   input logic slot);
        sel_n = ~(on & (idx == slot));
    endfunction

    // ----------------------------------------------------------------
    // pin assembly
    // ----------------------------------------------------------------
    // strobes and selects idle high; lines 19-25 belong to wider modes
    always_comb begin
        sig_o = '0;
        sig_oe = '0;
        if (ctl.en) begin
            sig_o[HBM_AD_HI:HBM_AD_LO] = ctl.ad_val;
            sig_oe[HBM_AD_HI:HBM_AD_LO] = {8{ctl.ad_oe}};
            sig_o[HBM_UA_HI:HBM_UA_LO] = ctl.addr[18:8];
            sig_oe[HBM_UA_HI:HBM_UA_LO] = {11{1'b1}};
            sig_o[HBM_PIN_RD] = ~ctl.rd;
            sig_o[HBM_PIN_WR] = ~ctl.wr;
            sig_oe[HBM_PIN_RD] = 1'b1;
            sig_oe[HBM_PIN_WR] = 1'b1;
            sig_oe[HBM_PIN_ALECS] = 1'b1;
            case (ctl.arr)
                HBM_ARR_ALE: begin
                    sig_o[HBM_PIN_ALECS] = ctl.ale;
                end
                HBM_ARR_CS1: begin
                    sig_o[HBM_PIN_ALECS] = ~ctl.cs_on;
                end
                HBM_ARR_CS2: begin
                    sig_o[HBM_PIN_ALECS] = sel_n(ctl.cs_on, ctl.cs_idx, 1'b0);
                    sig_o[HBM_PIN_CS1] = sel_n(ctl.cs_on, ctl.cs_idx, 1'b1);
                    sig_oe[HBM_PIN_CS1] = 1'b1;
                end
                default: begin
                    sig_o[HBM_PIN_ALECS] = ctl.ale;
                    sig_o[HBM_PIN_CS0B] = sel_n(ctl.cs_on, ctl.cs_idx, 1'b0);
                    sig_o[HBM_PIN_CS1] = sel_n(ctl.cs_on, ctl.cs_idx, 1'b1);
                    sig_oe[HBM_PIN_CS0B] = 1'b1;
                    sig_oe[HBM_PIN_CS1] = 1'b1;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* hbm_host_bus.sv */
// eight-bit muxed host bus access sequencer, top level
`timescale 1ns/1ps
`default_nettype none
module hbm_host_bus
    import hbm_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [3:0] TOP_MODE,
    input wire logic [1:0] HB_MODE,
    input wire logic [1:0] SEL_ARR,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [18:0] REQ_ADDR,
    input wire logic REQ_SEL,
    input wire logic [7:0] REQ_WDATA,
    output logic RSP_VALID,
    output logic [7:0] RSP_RDATA,
    output logic BUS_ACTIVE,
    input wire logic [7:0] IFACE_SIG_I,
    output logic [31:0] IFACE_SIG_O,
    output logic [31:0] IFACE_SIG_OE
);

    typedef struct packed {
        hbm_state_t st;
        logic [1:0] cnt;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic write;
        logic sel;
        logic [1:0] arr;
        logic [7:0] rdata;
        logic rvalid;
    } hbm_core_t;

    hbm_core_t cur_ff;
    hbm_core_t nxt_cur;
    logic enabled;
    logic ale_arr;

    hbm_ctl_if ctl ();

    // ----------------------------------------------------------------
    // mode qualification
    // ----------------------------------------------------------------
    // only the muxed eight-bit mode is served here
    assign enabled = (TOP_MODE == HBM_TOP_MODE_HB8)
                     && (HB_MODE == HBM_HB_MODE_MUX);
    assign ale_arr = (cur_ff.arr == HBM_ARR_ALE)
                     || (cur_ff.arr == HBM_ARR_ALE_CS2);
    assign REQ_READY = enabled && (cur_ff.st == HBM_IDLE);

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    // arrangement is frozen per access so a mid-access write is harmless
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rvalid = 1'b0;
        case (cur_ff.st)
            HBM_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    nxt_cur.st = HBM_ADDR;
                    nxt_cur.cnt = HBM_ADDR_LAST;
                    nxt_cur.addr = REQ_ADDR;
                    nxt_cur.wdata = REQ_WDATA;
                    nxt_cur.write = REQ_WRITE;
                    // one-select arrangement has only slot 0
                    nxt_cur.sel = (SEL_ARR == HBM_ARR_CS1) ? 1'b0 : REQ_SEL;
                    nxt_cur.arr = SEL_ARR;
                end
            end
            HBM_ADDR: begin
                if (cur_ff.cnt == 2'h0) begin
                    nxt_cur.st = HBM_HOLD;
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 2'h1;
                end
            end
            HBM_HOLD: begin
                // address stays on the lines one cycle after latch enable
                nxt_cur.st = HBM_STRB;
                nxt_cur.cnt = HBM_STROBE_LAST;
            end
            HBM_STRB: begin
                if (cur_ff.cnt == 2'h0) begin
                    nxt_cur.st = HBM_GAP;
                    nxt_cur.rvalid = 1'b1;
                    if (!cur_ff.write) begin
                        nxt_cur.rdata = IFACE_SIG_I;
                    end
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 2'h1;
                end
            end
            default: begin
                nxt_cur.st = HBM_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cur_ff <= '{st: HBM_IDLE, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ----------------------------------------------------------------
    // control bundle and outputs
    // ----------------------------------------------------------------
    assign ctl.en = enabled;
    assign ctl.ale = ale_arr && (cur_ff.st == HBM_ADDR);
    assign ctl.cs_on = (cur_ff.st == HBM_ADDR) || (cur_ff.st == HBM_HOLD)
                       || (cur_ff.st == HBM_STRB);
    assign ctl.cs_idx = cur_ff.sel;
    assign ctl.rd = (cur_ff.st == HBM_STRB) && !cur_ff.write;
    assign ctl.wr = (cur_ff.st == HBM_STRB) && cur_ff.write;
    // shared lines released while reading so the peripheral can drive
    assign ctl.ad_oe = (cur_ff.st == HBM_ADDR) || (cur_ff.st == HBM_HOLD)
                       || ((cur_ff.st == HBM_STRB) && cur_ff.write);
    assign ctl.ad_val = (cur_ff.st == HBM_STRB) ? cur_ff.wdata
                                                : cur_ff.addr[7:0];
    assign ctl.addr = cur_ff.addr;
    assign ctl.arr = cur_ff.arr;
    assign RSP_VALID = cur_ff.rvalid;
    assign RSP_RDATA = cur_ff.rdata;
    assign BUS_ACTIVE = ctl.cs_on;

    hbm_pin_map u_pin_map (
        .ctl(ctl.pins),
        .sig_o(IFACE_SIG_O),
        .sig_oe(IFACE_SIG_OE)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    property p_ready_mode;
        REQ_READY |-> TOP_MODE == HBM_TOP_MODE_HB8
                      && HB_MODE == HBM_HB_MODE_MUX;
    endproperty
    a_ready_mode: assert property (p_ready_mode)
        else $error("ready outside muxed eight-bit mode");

    // every arrangement shares the low lines, not only latch-enable ones
    property p_addr_low;
        enabled && (cur_ff.st == HBM_ADDR || cur_ff.st == HBM_HOLD)
            |-> IFACE_SIG_O[7:0] == cur_ff.addr[7:0]
                && IFACE_SIG_OE[7:0] == 8'hFF;
    endproperty
    a_addr_low: assert property (p_addr_low)
        else $error("low address byte not on shared lines");

    property p_addr_up;
        ctl.cs_on && enabled |-> IFACE_SIG_O[18:8] == cur_ff.addr[18:8];
    endproperty
    a_addr_up: assert property (p_addr_up)
        else $error("upper address lines wrong");

    property p_ale_pulse;
        $rose(ctl.ale) |-> ctl.ale[*2] ##1 !ctl.ale;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse)
        else $error("latch enable width wrong");

    // both strobes must be gone after two cycles, not only the read one
    property p_strobe_len;
        $rose(ctl.rd || ctl.wr) |-> (ctl.rd || ctl.wr)[*2]
            ##1 !(ctl.rd || ctl.wr);
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe width wrong");

    property p_read_cap;
        ctl.rd && cur_ff.cnt == 2'h0 |=> RSP_VALID
            && RSP_RDATA == $past(IFACE_SIG_I);
    endproperty
    a_read_cap: assert property (p_read_cap)
        else $error("read data not captured at strobe end");

    property p_strobe_after_ale;
        (ctl.rd || ctl.wr) |-> !ctl.ale && !$past(ctl.ale) && ctl.cs_on;
    endproperty
    a_strobe_after_ale: assert property (p_strobe_after_ale)
        else $error("strobe overlaps latch enable or lacks select");

    property p_cs1_arr;
        ctl.cs_on && enabled && cur_ff.arr == HBM_ARR_CS1
            |-> !IFACE_SIG_O[HBM_PIN_ALECS];
    endproperty
    a_cs1_arr: assert property (p_cs1_arr)
        else $error("single select not asserted");

    property p_one_cs;
        enabled && cur_ff.arr == HBM_ARR_ALE_CS2 |->
            IFACE_SIG_O[HBM_PIN_CS0B] || IFACE_SIG_O[HBM_PIN_CS1];
    endproperty
    a_one_cs: assert property (p_one_cs)
        else $error("two selects active together");

    // two-select arrangement: exactly one select low while busy, else none
    property p_one_cs2;
        enabled && cur_ff.arr == HBM_ARR_CS2 |->
            (IFACE_SIG_O[HBM_PIN_ALECS] != IFACE_SIG_O[HBM_PIN_CS1])
                == ctl.cs_on;
    endproperty
    a_one_cs2: assert property (p_one_cs2)
        else $error("two-select arrangement select count wrong");

    property p_gap;
        $fell(ctl.cs_on) |-> !ctl.cs_on ##1 !ctl.cs_on;
    endproperty
    a_gap: assert property (p_gap)
        else $error("selects not dropped between accesses");

endmodule
`default_nettype wire

/* hbm_periph_model.sv */
// partner model: external address latch and one byte-wide peripheral
`timescale 1ns/1ps
`default_nettype none
module hbm_periph_model
    import hbm_pkg::*;
(
    input wire logic clk,
    input wire logic [31:0] sig_o,
    input wire logic [31:0] sig_oe,
    output logic [7:0] sig_i,
    output logic [7:0] last_wdata
);
    logic [7:0] lat_ff = 8'h00;
    logic [7:0] prev_ff = 8'h00;
    logic rd_low;
    logic wr_low;

    // strobes count only while the device drives them
    assign rd_low = sig_oe[HBM_PIN_RD] && !sig_o[HBM_PIN_RD];
    assign wr_low = sig_oe[HBM_PIN_WR] && !sig_o[HBM_PIN_WR];

    // released lines show the inverse of the last value, never a hold
    assign sig_i = rd_low ? (lat_ff ^ 8'h5A) : ~prev_ff;

    // latch follows the shared lines in the address phase, then holds
    always @(posedge clk) begin
        prev_ff <= sig_i;
        if (sig_oe[HBM_AD_LO] && sig_o[HBM_PIN_RD] && sig_o[HBM_PIN_WR]) begin
            lat_ff <= sig_o[7:0];
        end
        if (wr_low) begin
            last_wdata <= sig_o[7:0];
        end
    end
endmodule
`default_nettype wire

/* test_host_bus_8bit_muxed_port.sv */
// self-checking bench for the eight-bit muxed host bus port
`timescale 1ns/1ps
`default_nettype none
module test_host_bus_8bit_muxed_port;
    import hbm_pkg::*;
    logic CLK = 1'b0, RSTN = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0;
    logic REQ_READY, RSP_VALID, BUS_ACTIVE, REQ_SEL = 1'b0;
    logic [3:0] TOP_MODE = 4'h2;
    logic [1:0] HB_MODE = 2'h0, SEL_ARR = 2'h0;
    logic [18:0] REQ_ADDR = 19'h00000;
    logic [7:0] REQ_WDATA = 8'h00, RSP_RDATA, sig_i, wdata_seen;
    logic [31:0] sig_o, sig_oe;
    int fail_count = 0, n_compared = 0, cyc = 0;
    // select pins {30,27,26}: enables, idle levels, chosen slot per arr
    localparam logic [2:0] OE_T[4] = '{3'b100, 3'b100, 3'b110, 3'b111};
    localparam logic [2:0] GAP_T[4] = '{3'b000, 3'b100, 3'b110, 3'b011};
    localparam logic [2:0] S0_T[4] = '{3'b000, 3'b100, 3'b100, 3'b001};
    localparam logic [2:0] S1_T[4] = '{3'b000, 3'b100, 3'b010, 3'b010};

    hbm_host_bus dut_u (.CLK(CLK), .RSTN(RSTN), .TOP_MODE(TOP_MODE),
        .HB_MODE(HB_MODE), .SEL_ARR(SEL_ARR), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
        .REQ_SEL(REQ_SEL), .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID),
        .RSP_RDATA(RSP_RDATA), .BUS_ACTIVE(BUS_ACTIVE),
        .IFACE_SIG_I(sig_i), .IFACE_SIG_O(sig_o), .IFACE_SIG_OE(sig_oe));
    hbm_periph_model peer_u (.clk(CLK), .sig_o(sig_o), .sig_oe(sig_oe),
        .sig_i(sig_i), .last_wdata(wdata_seen));

    // ----------------------------------------------------------------
    // clock, watchdog and reporting
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 CLK = ~CLK;
    end
    // about 20 accesses of 7 cycles; ceiling leaves a wide margin
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            results();
        end
    end
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // one access, walked cycle by cycle from the take edge
    // ----------------------------------------------------------------
    task automatic access(input logic w, input logic [18:0] a,
        input logic s, input logic [7:0] d, input logic [1:0] arr);
        int n;
        logic ale;
        logic [2:0] busy;
        n = 0;
        ale = (arr == HBM_ARR_ALE) || (arr == HBM_ARR_ALE_CS2);
        busy = GAP_T[arr] & ~(s ? S1_T[arr] : S0_T[arr]);
        @(posedge CLK);
        SEL_ARR <= arr;
        REQ_WRITE <= w;
        REQ_ADDR <= a;
        REQ_SEL <= s;
        REQ_WDATA <= d;
        REQ_VALID <= 1'b1;
        do begin
            @(negedge CLK);
            n++;
        end while (REQ_READY !== 1'b1 && n < 20);
        check("take_ready", 32'(REQ_READY), 32'h1);
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        @(negedge CLK);
        check("addr_lo", 32'(sig_o[7:0]), 32'(a[7:0]));
        check("addr_hi", 32'(sig_o[18:8]), 32'(a[18:8]));
        if (ale) check("ale_on", 32'(sig_o[30]), 32'h1);
        check("addr_hi_oe", 32'(sig_oe[18:8]), 32'h7FF);
        check("active_addr", 32'(BUS_ACTIVE), 32'h1);
        repeat (2) @(negedge CLK);
        check("hold_addr", 32'(sig_o[7:0]), 32'(a[7:0]));
        if (ale) check("ale_off", 32'(sig_o[30]), 32'h0);
        check("active_hold", 32'(BUS_ACTIVE), 32'h1);
        @(negedge CLK);
        check("strobes", 32'(sig_o[29:28]), w ? 32'h1 : 32'h2);
        check("sel_busy", 32'({sig_oe[30], sig_oe[27:26], sig_o[30],
            sig_o[27:26]}), 32'({OE_T[arr], busy}));
        check("active_strb", 32'(BUS_ACTIVE), 32'h1);
        check("ad_data", w ? 32'(sig_o[7:0]) : 32'(sig_oe[7:0]),
            w ? 32'(d) : 32'h0);
        repeat (2) @(negedge CLK);
        check("rsp", 32'(RSP_VALID), 32'h1);
        check("sel_gap", 32'({sig_o[30], sig_o[27:26]}),
            32'(GAP_T[arr]));
        check("active_gap", 32'(BUS_ACTIVE), 32'h0);
        if (w) check("wdata", 32'(wdata_seen), 32'(d));
        else check("rdata", 32'(RSP_RDATA), 32'(a[7:0] ^ 8'h5A));
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        @(negedge CLK);
        check("rdata_rst", 32'(RSP_RDATA), 32'h0);
        check("ready", 32'(REQ_READY), 32'h1);
        // every arrangement and slot, write then read back to back
        for (int arr = 0; arr < 4; arr++) begin
            for (int s = 0; s < 2; s++) begin
                access(1'b1, 19'h2A5C3 + 19'(arr * 37 + s * 11), s[0],
                    8'(8'hC3 + arr + s), arr[1:0]);
                access(1'b0, 19'h2A5C3 + 19'(arr * 37 + s * 11), s[0],
                    8'h00, arr[1:0]);
            end
        end
        access(1'b0, 19'h7FFFF, 1'b1, 8'h00, HBM_ARR_ALE_CS2);
        access(1'b1, 19'h00000, 1'b0, 8'hFF, HBM_ARR_ALE);
        // port stays dark outside the selected modes; wait for idle first
        // so a low ready proves the mode gate, not a busy sequencer
        @(posedge CLK);
        TOP_MODE <= 4'h1;
        @(negedge CLK);
        check("off_ready", 32'(REQ_READY), 32'h0);
        check("off_oe", sig_oe, 32'h0);
        @(posedge CLK);
        TOP_MODE <= HBM_TOP_MODE_HB8;
        HB_MODE <= 2'h1;
        @(negedge CLK);
        check("nomux_ready", 32'(REQ_READY), 32'h0);
        check("nomux_oe", sig_oe, 32'h0);
        @(posedge CLK);
        HB_MODE <= HBM_HB_MODE_MUX;
        // second reset mid-run: last read byte must clear, port works again
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        @(negedge CLK);
        check("rdata_rst2", 32'(RSP_RDATA), 32'h0);
        check("ready_rst2", 32'(REQ_READY), 32'h1);
        access(1'b0, 19'h10F0F, 1'b0, 8'h00, HBM_ARR_CS1);
        results();
    end
endmodule
`default_nettype wire
